/* bench/mre_host_model.sv */
// host model polling the report endpoint
`timescale 1ns/1ps
module mre_host_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pollReq,
  input  wire logic ackEn,
  input  wire logic epSend,
  output logic      epPoll,
  output logic      epAck
);
  // poll on request, ack a sent packet once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      epPoll <= 1'b0;
      epAck  <= 1'b0;
    end else begin
      epPoll <= pollReq;
      epAck  <= epSend & ackEn & !epAck;
    end
  end
endmodule // mre_host_model

/* bench/mre_report_endpoint_assertions.sv */
// port assertions for the report endpoint
`timescale 1ns/1ps
module mre_report_endpoint_assertions (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        usbConfigured,
  input wire logic        wheelFitted,
  input wire logic        epPoll,
  input wire logic        epAck,
  input wire logic        epSend,
  input wire logic        epNak,
  input wire logic [2:0]  epLen,
  input wire logic        regReq,
  input wire logic        regAck,
  input wire logic        setupValid,
  input wire logic [15:0] setupLength,
  input wire logic        replyValid,
  input wire logic [15:0] replyLen
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_UNCONF: assert property (!usbConfigured |-> !epSend && !epNak)
    else $error("poll answered while unconfigured");
  AST_POLL: assert property (epPoll && usbConfigured |-> epSend != epNak)
    else $error("poll answer not exactly one of send or nak");
  AST_HOLD: assert property (epSend && !epAck ##1 epPoll && usbConfigured |-> epSend)
    else $error("buffer emptied without ack");
  AST_LEN: assert property (epLen == (wheelFitted ? 3'h5 : 3'h4))
    else $error("packet length wrong");
  AST_REGACK: assert property (regReq |=> regAck)
    else $error("register access not acknowledged");
  AST_REPLY: assert property (setupValid |=> replyValid)
    else $error("setup not answered");
  AST_ZERO: assert property (setupValid && setupLength == 16'h0000 |=> replyLen <= 16'h0001)
    else $error("zero length reply too long");
  AST_PASS: assert property (setupValid && setupLength != 16'h0000 |=> replyLen == $past(setupLength))
    else $error("reply length not requested length");
endmodule // mre_report_endpoint_assertions
bind mre_report_endpoint mre_report_endpoint_assertions u_chk (.*);

/* bench/mre_report_endpoint_test.sv */
// self-checking bench for the report endpoint
`timescale 1ns/1ps
module mre_report_endpoint_test;
  import mre_pkg::*;
  logic        clk, rstn, analogSupplyPin, usbConfigured, usbBusReset, wheelFitted, motionValid, wheelValid, epPoll;
  logic        epAck, epSend, epNak, regReq, regWrite, regAck, setupValid, replyValid, statsValid, pollReq, ackEn;
  logic        useFusedOut;
  logic [2:0]  buttonPin, epLen;
  logic [11:0] motionDx, motionDy;
  logic [7:0]  idleRate, wheelDz, epByte0, epByte1, epByte2, epByte3, epByte4, regAddr, regWdata, regRdata;
  logic [7:0]  setupType, setupReq, statQuality, statPixMax, statPixSum, statPixMin, statPixGrab, resolutionOut;
  logic [15:0] setupIndex, setupLength, replyLen, statExposure, productCodeOut, vendorCodeOut;
  int          errors, n_checks, cycles;
  mre_report_endpoint #(.DEBOUNCE_CYCLES_P(4), .IDLE_UNIT_CYCLES_P(8)) dut (.*);
  mre_host_model host (.*);
  ////////////////////////////////////////
  // clock and hang limit
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(string n, logic [39:0] e, logic [39:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rg(logic w, logic [7:0] a, logic [7:0] d, logic [7:0] e);
    @(posedge clk) {regReq, regWrite, regAddr, regWdata} <= {1'b1, w, a, d};
    @(posedge clk) regReq <= 1'b0;
    @(negedge clk) chk("regAck", 1, regAck);
    if (!w) chk("regRdata", e, regRdata);
  endtask
  task automatic poll(logic s, logic [39:0] pk);
    @(posedge clk) pollReq <= 1'b1;
    @(posedge clk);
    @(posedge clk) pollReq <= 1'b0;
    @(negedge clk) chk("epSend", s, epSend);
    chk("epNak", usbConfigured & !s, epNak);
    if (s) chk("packet", pk, {epByte0, epByte1, epByte2, epByte3, epByte4});
    repeat (4) @(posedge clk);
  endtask
  task automatic move(logic [11:0] x, logic [11:0] y);
    @(posedge clk) {motionValid, wheelValid, motionDx, motionDy, wheelDz} <= {2'b11, x, y, 8'h01};
    @(posedge clk) {motionValid, wheelValid} <= 2'b00;
  endtask
  task automatic t_regs;
    logic [15:0] t [10] = '{16'h005A, 16'h0103, 16'h40FC, 16'h0932, 16'hE004, 16'hE212, 16'hE334, 16'hE443,
                            16'hE521, 16'h1000};
    foreach (t[i]) rg(0, t[i][15:8], 0, t[i][7:0]);
    @(posedge clk) {statsValid, statQuality, statExposure} <= {1'b1, 8'h5C, 16'hA1B2};
    @(posedge clk) statsValid <= 1'b0;
    rg(0, 8'h07, 0, 8'h5C);
    rg(0, 8'h08, 0, 8'hA1);
    rg(1, 8'hE0, 8'h07, 0);
    rg(0, 8'hE0, 0, 8'h07);
    rg(1, 8'hDF, 8'h01, 0);
    chk("outs", {8'h07, 16'h1234, 16'h4321}, {resolutionOut, productCodeOut, vendorCodeOut});
    chk("useFused", 1, useFusedOut);
    rg(1, 8'hE8, 8'h01, 0);
    rg(1, 8'hE0, 8'h09, 0);
    rg(0, 8'hE0, 0, 8'h07);
    @(posedge clk) usbBusReset <= 1'b1;
    rg(0, 8'hE0, 0, 8'h00);
    @(posedge clk) usbBusReset <= 1'b0;
    rg(0, 8'hE0, 0, 8'h04);
    @(posedge clk) analogSupplyPin <= 1'b0;
    repeat (3) @(posedge clk);
    rg(0, 8'h00, 0, 8'h00);
    @(posedge clk) analogSupplyPin <= 1'b1;
    repeat (3) @(posedge clk);
    $display("register test done");
  endtask
  task automatic t_setup;
    logic [31:0] t [8] = '{32'h80000000, 32'h81000000, 32'h82000000, 32'h82000081, 32'h80080000, 32'h810A0000,
                           32'h80060100, 32'h80000000};
    foreach (t[i]) begin
      @(posedge clk) {setupValid, setupType, setupReq, setupIndex} <= {1'b1, t[i]};
      setupLength <= (i == 7) ? 16'h0012 : 16'h0000;
      @(posedge clk) setupValid <= 1'b0;
      @(negedge clk) chk("replyLen", (i < 6) ? 1 : ((i == 7) ? 16'h0012 : 0), replyLen);
    end
    $display("setup test done");
  endtask
  task automatic t_motion;
    move(12'h005, 12'hFFD);
    poll(1, 40'h00_05_0F_FD_01);
    rg(0, 8'h04, 0, 8'h00);
    rg(0, 8'h03, 0, 8'h05);
    rg(0, 8'h04, 0, 8'hFD);
    rg(0, 8'h05, 0, 8'h0F);
    move(12'h002, 12'h000);
    move(12'h002, 12'h000);
    poll(1, 40'h00_05_0F_FD_01);
    @(posedge clk) ackEn <= 1'b1;
    poll(1, 40'h00_05_0F_FD_01);
    poll(1, 40'h00_04_00_00_02);
    poll(0, 0);
    $display("motion test done");
  endtask
  task automatic t_buttons;
    @(posedge clk) {ackEn, buttonPin} <= 4'b0001;
    repeat (12) @(posedge clk);
    poll(1, 40'h01_00_00_00_00);
    @(posedge clk) {ackEn, buttonPin} <= 4'b1011;
    repeat (12) @(posedge clk);
    poll(1, 40'h01_00_00_00_00);
    poll(1, 40'h03_00_00_00_00);
    poll(0, 0);
    rg(0, 8'h02, 0, 8'h03);
    $display("button test done");
  endtask
  task automatic t_unconf;
    @(posedge clk) {usbConfigured, wheelFitted} <= 2'b00;
    move(12'h001, 12'h001);
    poll(0, 0);
    @(posedge clk) {usbConfigured, wheelFitted} <= 2'b11;
    poll(0, 0);
    @(posedge clk) idleRate <= 8'h01;
    repeat (12) @(posedge clk);
    poll(1, 40'h03_00_00_00_00);
    $display("unconfigured test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // reset, then the scenarios
  initial begin
    {clk, rstn, usbBusReset, motionValid, wheelValid, pollReq, ackEn, regReq, regWrite, setupValid, statsValid} = '0;
    {analogSupplyPin, usbConfigured, wheelFitted, buttonPin, motionDx, motionDy, wheelDz, idleRate} = {3'b111, 43'h0};
    {regAddr, regWdata, setupType, setupReq, setupIndex, setupLength, statQuality, statExposure} = '0;
    {statPixMax, statPixSum, statPixMin, statPixGrab, errors, n_checks, cycles} = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_setup();
    t_motion();
    t_buttons();
    t_unconf();
    wrap_up();
  end
endmodule // mre_report_endpoint_test

/* src/mre_debounce.sv */
// one-bit debouncer: output follows input after it holds steady
`timescale 1ns/1ps

module mre_debounce
  import mre_pkg::*;
#(
  parameter int CNT_W  = DEBOUNCE_CNT_W,
  parameter int CYCLES = DEBOUNCE_CYCLES
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic sampleIn,
  output logic      stableOut
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic             stable_q;
  logic [CNT_W-1:0] cnt_q;

  wire differs = (sampleIn != stable_q);

  // restart the count whenever the input bounces back
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stable_q <= 1'b0;
      cnt_q    <= '0;
    end else if (!differs) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      stable_q <= sampleIn;
      cnt_q    <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  assign stableOut = stable_q;

endmodule // mre_debounce

/* src/mre_pkg.sv */
// constants shared by the report endpoint and its register file
//
// Overview of operation
// - No report packets are produced unless the USB device is configured.
// - An empty report buffer takes any new motion or button change at once.
// - While the buffer is full, X, Y and Z motion adds into accumulators.
// - When emptied, accumulated X/Y/Z moves into the buffer; accumulators then clear.
// - Each button state loaded into the buffer is also kept as a saved copy.
// - Button changes while the buffer is full are not separate events.
// - On emptying, a button state differing from the copy is loaded and copied.
// - Button inputs are debounced in hardware before reporting.
// - Listed get-status, get-configuration, get-interface with zero length answer one byte.
// - Registers are reachable over USB; supply loss or bus reset disables them.
// - Motion deltas are 12 bits; low bytes per axis, shared high-nibble register.
// - Idle rate zero sends reports only on data change, never periodically.
// - While configured, a poll with no pending report gets NAK, otherwise the pending packet.
// - Packet order: buttons, X low, XY high nibbles, Y low, then optional Z.
package mre_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int BTN_W   = 3;
  localparam int DELTA_W = 12;
  localparam int WHEEL_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_HZ           = 25_000_000;
  localparam int DEBOUNCE_US      = 5000;
  localparam int DEBOUNCE_CYCLES  = (DEBOUNCE_US * (CLK_HZ / 1_000_000));
  localparam int DEBOUNCE_CNT_W   = 17;
  localparam int IDLE_UNIT_US     = 4000;
  localparam int IDLE_UNIT_CYCLES = (IDLE_UNIT_US * (CLK_HZ / 1_000_000));
  localparam int IDLE_CNT_W       = 17;

  ////////////////////////////////////////////////////////////////////////////
  // report packet lengths
  localparam logic [2:0] LEN_NO_WHEEL   = 3'h4;
  localparam logic [2:0] LEN_WITH_WHEEL = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OFS_PRODUCT_ID    = 8'h00;
  localparam logic [7:0] OFS_REVISION_ID   = 8'h01;
  localparam logic [7:0] OFS_BUTTON_STATUS = 8'h02;
  localparam logic [7:0] OFS_MOTION_X_LOW  = 8'h03;
  localparam logic [7:0] OFS_MOTION_Y_LOW  = 8'h04;
  localparam logic [7:0] OFS_MOTION_XY_HI  = 8'h05;
  localparam logic [7:0] OFS_WHEEL_MOTION  = 8'h06;
  localparam logic [7:0] OFS_SURFACE_QUAL  = 8'h07;
  localparam logic [7:0] OFS_EXPOSURE_HI   = 8'h08;
  localparam logic [7:0] OFS_EXPOSURE_LO   = 8'h09;
  localparam logic [7:0] OFS_PIXEL_MAX     = 8'h0A;
  localparam logic [7:0] OFS_PIXEL_SUM     = 8'h0B;
  localparam logic [7:0] OFS_PIXEL_MIN     = 8'h0C;
  localparam logic [7:0] OFS_PIXEL_CAPTURE = 8'h0D;
  localparam logic [7:0] OFS_INV_REVISION  = 8'h40;
  localparam logic [7:0] OFS_FUSE_CLOCK    = 8'h42;
  localparam logic [7:0] OFS_FUSE_CONFIG   = 8'h51;
  localparam logic [7:0] OFS_FUSE_ADDR     = 8'h52;
  localparam logic [7:0] OFS_FUSE_DATA     = 8'h53;
  localparam logic [7:0] OFS_FUSE_CTRL     = 8'h54;
  localparam logic [7:0] OFS_FUSE_RUNSTAT  = 8'h56;
  localparam logic [7:0] OFS_FUSE_CTRLSTAT = 8'h58;
  localparam logic [7:0] OFS_USE_FUSED     = 8'hDF;
  localparam logic [7:0] OFS_RESOLUTION    = 8'hE0;
  localparam logic [7:0] OFS_PRODUCT_HI    = 8'hE2;
  localparam logic [7:0] OFS_PRODUCT_LO    = 8'hE3;
  localparam logic [7:0] OFS_VENDOR_HI     = 8'hE4;
  localparam logic [7:0] OFS_VENDOR_LO     = 8'hE5;
  localparam logic [7:0] OFS_FUSE_LOCK     = 8'hE8;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_EXPOSURE_LO = 8'h32;
  localparam logic [7:0] RST_RESOLUTION  = 8'h04;

  ////////////////////////////////////////////////////////////////////////////
  // setup request decode for the one-byte answer
  localparam logic [7:0] REQ_GET_STATUS = 8'h00;
  localparam logic [7:0] REQ_GET_CONFIG = 8'h08;
  localparam logic [7:0] REQ_GET_IFACE  = 8'h0A;
  localparam logic [7:0] TYPE_TO_DEVICE = 8'h80;
  localparam logic [7:0] TYPE_TO_IFACE  = 8'h81;
  localparam logic [7:0] TYPE_TO_EP     = 8'h82;
  localparam logic [7:0] EP_CONTROL     = 8'h00;
  localparam logic [7:0] EP_REPORT_IN   = 8'h81;
  localparam logic [15:0] LEN_ONE_BYTE  = 16'h0001;

endpackage : mre_pkg

/* src/mre_report_endpoint.sv */
// report endpoint buffering, motion accumulation and register file
`timescale 1ns/1ps

module mre_report_endpoint
  import mre_pkg::*;
#(
  parameter int         DEBOUNCE_CYCLES_P  = DEBOUNCE_CYCLES,
  parameter int         IDLE_UNIT_CYCLES_P = IDLE_UNIT_CYCLES,
  parameter logic [7:0]  PRODUCT_ID         = 8'h5A,    // arbitrary value
  parameter logic [7:0]  REVISION_ID        = 8'h03,    // arbitrary value
  parameter logic [15:0] PRODUCT_CODE_RST   = 16'h1234, // arbitrary value
  parameter logic [15:0] VENDOR_CODE_RST    = 16'h4321  // arbitrary value
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic [BTN_W-1:0]   buttonPin,
  input  wire logic               analogSupplyPin,
  input  wire logic               usbConfigured,
  input  wire logic               usbBusReset,
  input  wire logic [7:0]         idleRate,
  input  wire logic               wheelFitted,
  input  wire logic               motionValid,
  input  wire logic [DELTA_W-1:0] motionDx,
  input  wire logic [DELTA_W-1:0] motionDy,
  input  wire logic               wheelValid,
  input  wire logic [WHEEL_W-1:0] wheelDz,
  input  wire logic               epPoll,
  input  wire logic               epAck,
  output logic                    epSend,
  output logic                    epNak,
  output logic [2:0]              epLen,
  output logic [7:0]              epByte0,
  output logic [7:0]              epByte1,
  output logic [7:0]              epByte2,
  output logic [7:0]              epByte3,
  output logic [7:0]              epByte4,
  input  wire logic               regReq,
  input  wire logic               regWrite,
  input  wire logic [7:0]         regAddr,
  input  wire logic [7:0]         regWdata,
  output logic                    regAck,
  output logic [7:0]              regRdata,
  input  wire logic               setupValid,
  input  wire logic [7:0]         setupType,
  input  wire logic [7:0]         setupReq,
  input  wire logic [15:0]        setupIndex,
  input  wire logic [15:0]        setupLength,
  output logic                    replyValid,
  output logic [15:0]             replyLen,
  input  wire logic               statsValid,
  input  wire logic [7:0]         statQuality,
  input  wire logic [15:0]        statExposure,
  input  wire logic [7:0]         statPixMax,
  input  wire logic [7:0]         statPixSum,
  input  wire logic [7:0]         statPixMin,
  input  wire logic [7:0]         statPixGrab,
  output logic [7:0]              resolutionOut,
  output logic                    useFusedOut,
  output logic [15:0]             productCodeOut,
  output logic [15:0]             vendorCodeOut
);

  ////////////////////////////////////////////////////////////////////////////
  // saturating adders for the accumulators
  function automatic logic [DELTA_W-1:0] sat12(input logic [DELTA_W-1:0] a, input logic [DELTA_W-1:0] b);
    logic [DELTA_W:0] s;
    s = {a[DELTA_W-1], a} + {b[DELTA_W-1], b};
    sat12 = (s[DELTA_W] != s[DELTA_W-1]) ? (s[DELTA_W] ? 12'h800 : 12'h7FF) : s[DELTA_W-1:0];
  endfunction

  function automatic logic [WHEEL_W-1:0] sat8(input logic [WHEEL_W-1:0] a, input logic [WHEEL_W-1:0] b);
    logic [WHEEL_W:0] s;
    s = {a[WHEEL_W-1], a} + {b[WHEEL_W-1], b};
    sat8 = (s[WHEEL_W] != s[WHEEL_W-1]) ? (s[WHEEL_W] ? 8'h80 : 8'h7F) : s[WHEEL_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [BTN_W-1:0] btnMeta_q, btnSync_q;
  logic             supplyMeta_q, supplySync_q;

  // two flops on every pin before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      btnMeta_q    <= '0;
      btnSync_q    <= '0;
      supplyMeta_q <= 1'b0;
      supplySync_q <= 1'b0;
    end else begin
      btnMeta_q    <= buttonPin;
      btnSync_q    <= btnMeta_q;
      supplyMeta_q <= analogSupplyPin;
      supplySync_q <= supplyMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // button debouncers
  logic [BTN_W-1:0] btnDeb;
  for (genvar i = 0; i < BTN_W; i++) begin : g_deb
    mre_debounce #(
      .CNT_W  (DEBOUNCE_CNT_W),
      .CYCLES (DEBOUNCE_CYCLES_P)
    ) u_deb (
      .clk       (clk),
      .rstn      (rstn),
      .sampleIn  (btnSync_q[i]),
      .stableOut (btnDeb[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // report state
  logic                  bufFull_q;
  logic [DELTA_W-1:0]    accX_q, accY_q, repX_q, repY_q;
  logic [WHEEL_W-1:0]    accZ_q, repZ_q;
  logic [BTN_W-1:0]      savedBtn_q, repBtn_q;
  logic [IDLE_CNT_W-1:0] unitCnt_q;
  logic [7:0]            idleCnt_q;
  localparam logic [IDLE_CNT_W-1:0] UNIT_LAST = IDLE_CNT_W'(IDLE_UNIT_CYCLES_P - 1);
  // incoming motion, zero when no event this cycle
  wire [DELTA_W-1:0] inDx = motionValid ? motionDx : '0;
  wire [DELTA_W-1:0] inDy = motionValid ? motionDy : '0;
  wire [WHEEL_W-1:0] inDz = wheelValid ? wheelDz : '0;
  // accumulated motion including this cycle's event
  wire [DELTA_W-1:0] sumX = sat12(accX_q, inDx);
  wire [DELTA_W-1:0] sumY = sat12(accY_q, inDy);
  wire [WHEEL_W-1:0] sumZ = sat8(accZ_q, inDz);
  // load decision; only the empty buffer looks at button changes
  wire active    = usbConfigured;
  wire hasMotion = (|sumX) | (|sumY) | (|sumZ);
  wire btnChange = (btnDeb != savedBtn_q);
  wire idleDue   = (idleRate != 8'h00) && (idleCnt_q >= idleRate);
  wire loadNow   = active && !bufFull_q && (hasMotion || btnChange || idleDue);
  wire unitWrap  = (unitCnt_q == UNIT_LAST);
  // buffer occupancy: loaded when empty, freed by the host's ack
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      bufFull_q <= 1'b0;
    else if (!active)
      bufFull_q <= 1'b0;
    else if (loadNow)
      bufFull_q <= 1'b1;
    else if (epAck && bufFull_q)
      bufFull_q <= 1'b0;
  end
  // accumulators: drained into the buffer on a load, else keep adding
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accX_q <= '0;
      accY_q <= '0;
      accZ_q <= '0;
    end else if (!active || loadNow) begin
      accX_q <= '0;
      accY_q <= '0;
      accZ_q <= '0;
    end else begin
      accX_q <= sumX;
      accY_q <= sumY;
      accZ_q <= sumZ;
    end
  end
  // buffer contents and the saved button copy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      repBtn_q   <= '0;
      savedBtn_q <= '0;
      repX_q     <= '0;
      repY_q     <= '0;
      repZ_q     <= '0;
    end else if (loadNow) begin
      repBtn_q   <= btnDeb;
      savedBtn_q <= btnDeb;
      repX_q     <= sumX;
      repY_q     <= sumY;
      repZ_q     <= sumZ;
    end
  end
  // idle period timer in 4 ms units, restarted by every load
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unitCnt_q <= '0;
      idleCnt_q <= 8'h00;
    end else if (!active || loadNow || (idleRate == 8'h00)) begin
      unitCnt_q <= '0;
      idleCnt_q <= 8'h00;
    end else if (unitWrap) begin
      unitCnt_q <= '0;
      idleCnt_q <= (idleCnt_q == 8'hFF) ? idleCnt_q : idleCnt_q + 8'h01;
    end else begin
      unitCnt_q <= unitCnt_q + IDLE_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // poll answer; polls while unconfigured get no answer
  assign epSend  = epPoll && active && bufFull_q;
  assign epNak   = epPoll && active && !bufFull_q;
  assign epLen   = wheelFitted ? LEN_WITH_WHEEL : LEN_NO_WHEEL;
  assign epByte0 = {{(8 - BTN_W){1'b0}}, repBtn_q};
  assign epByte1 = repX_q[7:0];
  assign epByte2 = {repX_q[11:8], repY_q[11:8]};
  assign epByte3 = repY_q[7:0];
  assign epByte4 = repZ_q;

  ////////////////////////////////////////////////////////////////////////////
  // one-byte answer for zero-length standard requests
  wire isStatus = (setupReq == REQ_GET_STATUS) &&
                  ((setupType == TYPE_TO_DEVICE) || (setupType == TYPE_TO_IFACE) ||
                   ((setupType == TYPE_TO_EP) &&
                    ((setupIndex[7:0] == EP_CONTROL) || (setupIndex[7:0] == EP_REPORT_IN))));
  wire isConfig = (setupReq == REQ_GET_CONFIG) && (setupType == TYPE_TO_DEVICE);
  wire isIface  = (setupReq == REQ_GET_IFACE) && (setupType == TYPE_TO_IFACE);
  wire quirkHit = (isStatus || isConfig || isIface) && (setupLength == 16'h0000);
  logic        replyValid_q;
  logic [15:0] replyLen_q;
  // answer length one cycle after the setup stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      replyValid_q <= 1'b0;
      replyLen_q   <= 16'h0000;
    end else begin
      replyValid_q <= setupValid;
      if (setupValid)
        replyLen_q <= quirkHit ? LEN_ONE_BYTE : setupLength;
    end
  end
  assign replyValid = replyValid_q;
  assign replyLen   = replyLen_q;

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0]  quality_q, pixMax_q, pixSum_q, pixMin_q, pixGrab_q;
  logic [7:0]  fuseClock_q, fuseConfig_q, fuseAddr_q, fuseData_q, fuseCtrl_q;
  logic [7:0]  useFused_q, resolution_q, fuseLock_q, regRdata_q;
  logic [15:0] exposure_q, productCode_q, vendorCode_q;
  logic        xRead_q, regAck_q;
  // registers are live only with supply up and no bus reset
  wire regsOn  = supplySync_q && !usbBusReset;
  wire rdStrb  = regReq && !regWrite && regsOn;
  wire wrStrb  = regReq && regWrite && regsOn;
  wire wrFused = wrStrb && (fuseLock_q == 8'h00); // locked fuse image refuses writes
  // y low and xy high read zero until x low has been read
  wire [7:0] rdYLow = xRead_q ? repY_q[7:0] : 8'h00;
  wire [7:0] rdXYHi = xRead_q ? {repX_q[11:8], repY_q[11:8]} : 8'h00;
  // read selection
  wire [7:0] rdMux =
    ({8{regAddr == OFS_PRODUCT_ID}}    & PRODUCT_ID) |
    ({8{regAddr == OFS_REVISION_ID}}   & REVISION_ID) |
    ({8{regAddr == OFS_BUTTON_STATUS}} & {{(8 - BTN_W){1'b0}}, btnDeb}) |
    ({8{regAddr == OFS_MOTION_X_LOW}}  & repX_q[7:0]) |
    ({8{regAddr == OFS_MOTION_Y_LOW}}  & rdYLow) |
    ({8{regAddr == OFS_MOTION_XY_HI}}  & rdXYHi) |
    ({8{regAddr == OFS_WHEEL_MOTION}}  & repZ_q) |
    ({8{regAddr == OFS_SURFACE_QUAL}}  & quality_q) |
    ({8{regAddr == OFS_EXPOSURE_HI}}   & exposure_q[15:8]) |
    ({8{regAddr == OFS_EXPOSURE_LO}}   & exposure_q[7:0]) |
    ({8{regAddr == OFS_PIXEL_MAX}}     & pixMax_q) |
    ({8{regAddr == OFS_PIXEL_SUM}}     & pixSum_q) |
    ({8{regAddr == OFS_PIXEL_MIN}}     & pixMin_q) |
    ({8{regAddr == OFS_PIXEL_CAPTURE}} & pixGrab_q) |
    ({8{regAddr == OFS_INV_REVISION}}  & ~REVISION_ID) |
    ({8{regAddr == OFS_FUSE_CLOCK}}    & fuseClock_q) |
    ({8{regAddr == OFS_FUSE_CONFIG}}   & fuseConfig_q) |
    ({8{regAddr == OFS_FUSE_ADDR}}     & fuseAddr_q) |
    ({8{regAddr == OFS_FUSE_DATA}}     & fuseData_q) |
    ({8{regAddr == OFS_FUSE_CTRL}}     & fuseCtrl_q) |
    ({8{regAddr == OFS_USE_FUSED}}     & useFused_q) |
    ({8{regAddr == OFS_RESOLUTION}}    & resolution_q) |
    ({8{regAddr == OFS_PRODUCT_HI}}    & productCode_q[15:8]) |
    ({8{regAddr == OFS_PRODUCT_LO}}    & productCode_q[7:0]) |
    ({8{regAddr == OFS_VENDOR_HI}}     & vendorCode_q[15:8]) |
    ({8{regAddr == OFS_VENDOR_LO}}     & vendorCode_q[7:0]) |
    ({8{regAddr == OFS_FUSE_LOCK}}     & fuseLock_q);
  // every request answers next cycle; disabled or unmapped reads give zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regAck_q   <= 1'b0;
      regRdata_q <= RST_ZERO;
    end else begin
      regAck_q <= regReq;
      if (regReq)
        regRdata_q <= rdStrb ? rdMux : RST_ZERO;
    end
  end
  // read-order flag: armed by x low, spent by the high-nibble read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      xRead_q <= 1'b0;
    else if (!regsOn)
      xRead_q <= 1'b0;
    else if (rdStrb && (regAddr == OFS_MOTION_X_LOW))
      xRead_q <= 1'b1;
    else if (rdStrb && (regAddr == OFS_MOTION_XY_HI))
      xRead_q <= 1'b0;
  end
  // image statistics captured from the tracking engine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      quality_q  <= RST_ZERO;
      exposure_q <= {RST_ZERO, RST_EXPOSURE_LO};
      pixMax_q   <= RST_ZERO;
      pixSum_q   <= RST_ZERO;
      pixMin_q   <= RST_ZERO;
      pixGrab_q  <= RST_ZERO;
    end else if (statsValid) begin
      quality_q  <= statQuality;
      exposure_q <= statExposure;
      pixMax_q   <= statPixMax;
      pixSum_q   <= statPixSum;
      pixMin_q   <= statPixMin;
      pixGrab_q  <= statPixGrab;
    end
  end
  // fuse access registers, restored while the register file is disabled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fuseClock_q  <= RST_ZERO;
      fuseConfig_q <= RST_ZERO;
      fuseAddr_q   <= RST_ZERO;
      fuseData_q   <= RST_ZERO;
      fuseCtrl_q   <= RST_ZERO;
    end else if (!regsOn) begin
      fuseClock_q  <= RST_ZERO;
      fuseConfig_q <= RST_ZERO;
      fuseAddr_q   <= RST_ZERO;
      fuseData_q   <= RST_ZERO;
      fuseCtrl_q   <= RST_ZERO;
    end else if (wrStrb) begin
      if (regAddr == OFS_FUSE_CLOCK)  fuseClock_q  <= regWdata;
      if (regAddr == OFS_FUSE_CONFIG) fuseConfig_q <= regWdata;
      if (regAddr == OFS_FUSE_ADDR)   fuseAddr_q   <= regWdata;
      if (regAddr == OFS_FUSE_DATA)   fuseData_q   <= regWdata;
      if (regAddr == OFS_FUSE_CTRL)   fuseCtrl_q   <= regWdata;
    end
  end
  // fused settings image; lock register blocks further writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      useFused_q    <= RST_ZERO;
      resolution_q  <= RST_RESOLUTION;
      productCode_q <= PRODUCT_CODE_RST;
      vendorCode_q  <= VENDOR_CODE_RST;
      fuseLock_q    <= RST_ZERO;
    end else if (!regsOn) begin
      useFused_q    <= RST_ZERO;
      resolution_q  <= RST_RESOLUTION;
      productCode_q <= PRODUCT_CODE_RST;
      vendorCode_q  <= VENDOR_CODE_RST;
      fuseLock_q    <= RST_ZERO;
    end else if (wrFused) begin
      if (regAddr == OFS_USE_FUSED)  useFused_q          <= regWdata;
      if (regAddr == OFS_RESOLUTION) resolution_q        <= regWdata;
      if (regAddr == OFS_PRODUCT_HI) productCode_q[15:8] <= regWdata;
      if (regAddr == OFS_PRODUCT_LO) productCode_q[7:0]  <= regWdata;
      if (regAddr == OFS_VENDOR_HI)  vendorCode_q[15:8]  <= regWdata;
      if (regAddr == OFS_VENDOR_LO)  vendorCode_q[7:0]   <= regWdata;
      if (regAddr == OFS_FUSE_LOCK)  fuseLock_q          <= regWdata;
    end
  end
  assign regAck         = regAck_q;
  assign regRdata       = regRdata_q;
  assign resolutionOut  = resolution_q;
  assign useFusedOut    = useFused_q[0];
  assign productCodeOut = productCode_q;
  assign vendorCodeOut  = vendorCode_q;

endmodule // mre_report_endpoint
